// ==== rtl/dcs_consts.svh ====
// Timing constants and reset values for the dead-time, capacitive-mode and overcurrent sequencer.
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// Clock period in picoseconds (250 MHz).
`define DCS_CLK_PERIOD_PS 4000

// Printed times in their own units.
`define DCS_MIN_DT_NS 235
`define DCS_MAX_DT_NS 1000
`define DCS_FIX_DT_NS 300
`define DCS_CMP_TIMEOUT_US 52
`define DCS_OCP_HOLD_US 10

// Conversion helpers: least times round up, longest times round down.
`define DCS_CYC_CEIL(ps) (((ps) + `DCS_CLK_PERIOD_PS - 1) / `DCS_CLK_PERIOD_PS)
`define DCS_CYC_FLOOR(ps) ((ps) / `DCS_CLK_PERIOD_PS)

// Derived cycle counts.
`define DCS_MIN_DT_CYC `DCS_CYC_CEIL(`DCS_MIN_DT_NS * 1000)
`define DCS_MAX_DT_CYC `DCS_CYC_FLOOR(`DCS_MAX_DT_NS * 1000)
`define DCS_FIX_DT_CYC `DCS_CYC_CEIL(`DCS_FIX_DT_NS * 1000)
`define DCS_CMP_TIMEOUT_CYC `DCS_CYC_FLOOR(`DCS_CMP_TIMEOUT_US * 1000000)
`define DCS_OCP_HOLD_CYC `DCS_CYC_CEIL(`DCS_OCP_HOLD_US * 1000000)

// Counter widths and synchroniser reset value.
`define DCS_CNT_W 16
`define DCS_HOLD_W 12
`define DCS_SYNC_RST 9'h000

`endif

// ==== rtl/dcs_pkg.sv ====
// Types shared by the sequencer modules.
package dcs_pkg;

  // Comparator and status inputs that need synchronising.
  typedef struct packed {
    logic slew;
    logic pos_pol;
    logic neg_pol;
    logic oc_level1;
    logic oc_level2;
    logic timer_first;
    logic timer_shutdown;
    logic timer_restart;
    logic undervoltage_lockout;
  } dcs_cmp_s;

  // Gate sequencing states.
  typedef enum logic [2:0] {
    DCS_ST_OFF,
    DCS_ST_HIGH_ON,
    DCS_ST_LOW_ON,
    DCS_ST_DT_TO_LOW,
    DCS_ST_DT_TO_HIGH
  } dcs_gate_e;

  // Overcurrent sequencing states.
  typedef enum logic [2:0] {
    DCS_OC_IDLE,
    DCS_OC_REGULATE,
    DCS_OC_PROTECT,
    DCS_OC_HICCUP,
    DCS_OC_LATCHED
  } dcs_ocp_e;

endpackage

// ==== rtl/dcs_cmp_if.sv ====
// Interface carrying synchronised comparator results between the sequencer modules.
`timescale 1ns/1ps
`default_nettype none

interface dcs_cmp_if;
  dcs_pkg::dcs_cmp_s cmp;

  // The synchroniser drives, the sequencer reads.
  modport src (output cmp);
  modport dst (input cmp);
endinterface

`default_nettype wire

// ==== rtl/dcs_sync.sv ====
// Two-stage synchroniser for the comparator inputs of the sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.svh"

module dcs_sync (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire dcs_pkg::dcs_cmp_s raw_i,
  dcs_cmp_if.src                 out
);

  dcs_pkg::dcs_cmp_s meta_q;
  dcs_pkg::dcs_cmp_s sync_q;

  // First stage feeds only the second stage, so metastability never reaches decisions.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= `DCS_SYNC_RST;
      sync_q <= `DCS_SYNC_RST;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
    end
  end

  // Only the second stage is visible to the sequencer.
  assign out.cmp = sync_q;

endmodule

`default_nettype wire

// ==== rtl/dcs_sequencer.sv ====
// Dead-time, capacitive-mode guard and overcurrent sequencer for a resonant half-bridge.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.svh"

module dcs_sequencer #(
  parameter int CNT_W           = `DCS_CNT_W,
  parameter int HOLD_W          = `DCS_HOLD_W,
  parameter int CMP_TIMEOUT_CYC = `DCS_CMP_TIMEOUT_CYC,
  parameter int OCP_HOLD_CYC    = `DCS_OCP_HOLD_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic osc_phase_i,
  input  wire logic slew_sense_i,
  input  wire logic positive_polarity_flag_i,
  input  wire logic negative_polarity_flag_i,
  input  wire logic oc_level1_i,
  input  wire logic oc_level2_i,
  input  wire logic timer_first_i,
  input  wire logic timer_shutdown_i,
  input  wire logic timer_restart_i,
  input  wire logic undervoltage_lockout_i,
  output logic      high_side_gate_o,
  output logic      low_side_gate_o,
  output logic      deadtime_active_o,
  output logic      osc_halt_o,
  output logic      ss_discharge_o,
  output logic      timer_charge_o,
  output logic      capacitive_mode_o,
  output logic      overcurrent_latched_o
);

  // Cycle thresholds at counter width.
  localparam logic [CNT_W-1:0]  MIN_DT      = CNT_W'(`DCS_MIN_DT_CYC);
  localparam logic [CNT_W-1:0]  MAX_DT      = CNT_W'(`DCS_MAX_DT_CYC);
  localparam logic [CNT_W-1:0]  FIX_DT      = CNT_W'(`DCS_FIX_DT_CYC);
  localparam logic [CNT_W-1:0]  CMP_TIMEOUT = CNT_W'(CMP_TIMEOUT_CYC);
  localparam logic [HOLD_W-1:0] OCP_HOLD    = HOLD_W'(OCP_HOLD_CYC);

  // Saturating increment, used by the dead-time counter only; the hold counter stops at OCP_HOLD on its own.
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    r = v;
    if (v != {CNT_W{1'b1}}) begin
      r = v + CNT_W'(1);
    end
    return r;
  endfunction

  // Comparator synchronisation.
  dcs_cmp_if         cmp_bus ();
  dcs_pkg::dcs_cmp_s raw_cmp;

  assign raw_cmp.slew           = slew_sense_i;
  assign raw_cmp.pos_pol        = positive_polarity_flag_i;
  assign raw_cmp.neg_pol        = negative_polarity_flag_i;
  assign raw_cmp.oc_level1      = oc_level1_i;
  assign raw_cmp.oc_level2      = oc_level2_i;
  assign raw_cmp.timer_first    = timer_first_i;
  assign raw_cmp.timer_shutdown = timer_shutdown_i;
  assign raw_cmp.timer_restart  = timer_restart_i;
  assign raw_cmp.undervoltage_lockout           = undervoltage_lockout_i;

  // All comparator results pass two flip-flops before use.
  dcs_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .raw_i (raw_cmp),
    .out   (cmp_bus.src)
  );

  dcs_pkg::dcs_gate_e state_q;
  dcs_pkg::dcs_ocp_e  ocp_q;
  logic [CNT_W-1:0]   dt_cnt_q;
  logic [HOLD_W-1:0]  hold_cnt_q;
  logic               hs_q;
  logic               ls_q;
  logic               slew_seen_q;
  logic               slew_alive_q;
  logic               cap_block_q;
  logic               ss_cmp_q;
  logic               ss_ocp_q;
  logic               charge_q;
  logic               shutdown;
  logic               hs_off_evt;
  logic               ls_off_evt;
  logic               min_ok;
  logic               max_ok;
  logic               fix_ok;
  logic               cmp_expired;
  logic               low_on_ok;
  logic               high_on_ok;

  // Gates are held off by hiccup, the latched state or supply lockout.
  assign shutdown = (ocp_q == dcs_pkg::DCS_OC_HICCUP) || (ocp_q == dcs_pkg::DCS_OC_LATCHED) || cmp_bus.cmp.undervoltage_lockout;

  // Normal turn-off events follow the oscillator phase.
  assign hs_off_evt = (state_q == dcs_pkg::DCS_ST_HIGH_ON) && !osc_phase_i;
  assign ls_off_evt = (state_q == dcs_pkg::DCS_ST_LOW_ON) && osc_phase_i;

  // Dead-time thresholds.
  assign min_ok      = dt_cnt_q >= MIN_DT;
  assign max_ok      = dt_cnt_q >= MAX_DT;
  assign fix_ok      = dt_cnt_q >= FIX_DT;
  assign cmp_expired = dt_cnt_q >= CMP_TIMEOUT;

  // Low-side turn-on waits for the falling edge to end and the sense to recover.
  always_comb begin
    low_on_ok = 1'b0;
    if (min_ok) begin
      if (cap_block_q) begin
        low_on_ok = (cmp_bus.cmp.pos_pol && slew_seen_q && !cmp_bus.cmp.slew) || cmp_expired;
      end else if (!slew_alive_q) begin
        low_on_ok = fix_ok;
      end else begin
        low_on_ok = (slew_seen_q && !cmp_bus.cmp.slew) || max_ok;
      end
    end
  end

  // High-side turn-on is taken from the detection of the rising-edge current.
  always_comb begin
    high_on_ok = 1'b0;
    if (min_ok) begin
      if (cap_block_q) begin
        high_on_ok = (cmp_bus.cmp.neg_pol && (slew_seen_q || cmp_bus.cmp.slew)) || cmp_expired;
      end else if (!slew_alive_q) begin
        high_on_ok = fix_ok;
      end else begin
        high_on_ok = slew_seen_q || cmp_bus.cmp.slew || max_ok;
      end
    end
  end

  // Gate state machine; only one gate flip-flop can be set at a time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= dcs_pkg::DCS_ST_OFF;
      hs_q        <= 1'b0;
      ls_q        <= 1'b0;
      dt_cnt_q    <= '0;
      slew_seen_q <= 1'b0;
      cap_block_q <= 1'b0;
    end else if (shutdown) begin
      state_q     <= dcs_pkg::DCS_ST_OFF;
      hs_q        <= 1'b0;
      ls_q        <= 1'b0;
      dt_cnt_q    <= '0;
      slew_seen_q <= 1'b0;
      cap_block_q <= 1'b0;
    end else begin
      case (state_q)
        dcs_pkg::DCS_ST_OFF: begin
          // Restart on the low side so the bootstrap supply charges first.
          state_q     <= dcs_pkg::DCS_ST_DT_TO_LOW;
          dt_cnt_q    <= '0;
          slew_seen_q <= 1'b0;
          cap_block_q <= 1'b0;
        end
        dcs_pkg::DCS_ST_HIGH_ON: begin
          if (hs_off_evt) begin
            hs_q        <= 1'b0;
            state_q     <= dcs_pkg::DCS_ST_DT_TO_LOW;
            dt_cnt_q    <= '0;
            slew_seen_q <= 1'b0;
            cap_block_q <= !cmp_bus.cmp.pos_pol;
          end
        end
        dcs_pkg::DCS_ST_LOW_ON: begin
          if (ls_off_evt) begin
            ls_q        <= 1'b0;
            state_q     <= dcs_pkg::DCS_ST_DT_TO_HIGH;
            dt_cnt_q    <= '0;
            slew_seen_q <= 1'b0;
            cap_block_q <= !cmp_bus.cmp.neg_pol;
          end
        end
        dcs_pkg::DCS_ST_DT_TO_LOW: begin
          dt_cnt_q <= sat_inc(dt_cnt_q);
          if (cmp_bus.cmp.slew) begin
            slew_seen_q <= 1'b1;
          end
          if (low_on_ok && !hs_q) begin
            ls_q        <= 1'b1;
            state_q     <= dcs_pkg::DCS_ST_LOW_ON;
            cap_block_q <= 1'b0;
          end
        end
        dcs_pkg::DCS_ST_DT_TO_HIGH: begin
          dt_cnt_q <= sat_inc(dt_cnt_q);
          if (cmp_bus.cmp.slew) begin
            slew_seen_q <= 1'b1;
          end
          if (high_on_ok && !ls_q) begin
            hs_q        <= 1'b1;
            state_q     <= dcs_pkg::DCS_ST_HIGH_ON;
            cap_block_q <= 1'b0;
          end
        end
        default: begin
          state_q <= dcs_pkg::DCS_ST_OFF;
          hs_q    <= 1'b0;
          ls_q    <= 1'b0;
        end
      endcase
    end
  end

  // Remembers whether slew sensing has ever worked; an open sense pin never sets it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slew_alive_q <= 1'b0;
    end else if (cmp_bus.cmp.slew) begin
      slew_alive_q <= 1'b1;
    end
  end

  // Soft-start discharge after a capacitive event; the next turn-off releases it.
  // A turn-off that detects a new event sets it again, so the set wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_cmp_q <= 1'b0;
    end else if (hs_off_evt) begin
      ss_cmp_q <= !cmp_bus.cmp.pos_pol;
    end else if (ls_off_evt) begin
      ss_cmp_q <= !cmp_bus.cmp.neg_pol;
    end
  end

  // Overcurrent sequencing: regulate, protect, hiccup or latch.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocp_q      <= dcs_pkg::DCS_OC_IDLE;
      hold_cnt_q <= '0;
      ss_ocp_q   <= 1'b0;
      charge_q   <= 1'b0;
    end else if (cmp_bus.cmp.oc_level2 && (ocp_q != dcs_pkg::DCS_OC_LATCHED)) begin
      ocp_q    <= dcs_pkg::DCS_OC_LATCHED;
      ss_ocp_q <= 1'b1;
      charge_q <= 1'b0;
    end else begin
      case (ocp_q)
        dcs_pkg::DCS_OC_IDLE: begin
          if (cmp_bus.cmp.oc_level1) begin
            ocp_q      <= dcs_pkg::DCS_OC_REGULATE;
            hold_cnt_q <= '0;
            ss_ocp_q   <= 1'b1;
            charge_q   <= 1'b1;
          end
        end
        dcs_pkg::DCS_OC_REGULATE: begin
          if (hold_cnt_q != OCP_HOLD) begin
            hold_cnt_q <= hold_cnt_q + HOLD_W'(1);
          end
          if (cmp_bus.cmp.timer_first && cmp_bus.cmp.oc_level1) begin
            ocp_q <= dcs_pkg::DCS_OC_PROTECT;
          end else if (!cmp_bus.cmp.oc_level1 && (hold_cnt_q == OCP_HOLD)) begin
            ocp_q    <= dcs_pkg::DCS_OC_IDLE;
            ss_ocp_q <= 1'b0;
            charge_q <= 1'b0;
          end
        end
        dcs_pkg::DCS_OC_PROTECT: begin
          if (cmp_bus.cmp.timer_shutdown) begin
            ocp_q    <= dcs_pkg::DCS_OC_HICCUP;
            charge_q <= 1'b0;
          end else if (!cmp_bus.cmp.oc_level1) begin
            ocp_q    <= dcs_pkg::DCS_OC_IDLE;
            ss_ocp_q <= 1'b0;
            charge_q <= 1'b0;
          end
        end
        dcs_pkg::DCS_OC_HICCUP: begin
          // Soft-start stays discharged so switching restarts gently.
          if (cmp_bus.cmp.timer_restart) begin
            ocp_q    <= dcs_pkg::DCS_OC_IDLE;
            ss_ocp_q <= 1'b0;
          end
        end
        dcs_pkg::DCS_OC_LATCHED: begin
          if (cmp_bus.cmp.undervoltage_lockout) begin
            ocp_q    <= dcs_pkg::DCS_OC_IDLE;
            ss_ocp_q <= 1'b0;
          end
        end
        default: begin
          ocp_q    <= dcs_pkg::DCS_OC_IDLE;
          ss_ocp_q <= 1'b0;
          charge_q <= 1'b0;
        end
      endcase
    end
  end

  // Outputs decode flip-flops only.
  assign high_side_gate_o      = hs_q;
  assign low_side_gate_o       = ls_q;
  assign deadtime_active_o     = (state_q == dcs_pkg::DCS_ST_DT_TO_LOW) || (state_q == dcs_pkg::DCS_ST_DT_TO_HIGH);
  assign osc_halt_o            = deadtime_active_o && cap_block_q;
  assign capacitive_mode_o     = cap_block_q;
  assign ss_discharge_o        = ss_cmp_q || ss_ocp_q;
  assign timer_charge_o        = charge_q;
  assign overcurrent_latched_o = (ocp_q == dcs_pkg::DCS_OC_LATCHED);

endmodule

`default_nettype wire

// ==== verification/dcs_seq_assertions.sv ====
// Concurrent checks on the port behaviour of the half-bridge sequencer.
`timescale 1ns/1ps
`default_nettype none

module dcs_seq_assertions #(
  parameter int CMP_TIMEOUT_CYC = 13000,
  parameter int OCP_HOLD_CYC    = 2500
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slew_sense_i,
  input wire logic oc_level1_i,
  input wire logic oc_level2_i,
  input wire logic timer_first_i,
  input wire logic timer_shutdown_i,
  input wire logic undervoltage_lockout_i,
  input wire logic high_side_gate_o,
  input wire logic low_side_gate_o,
  input wire logic deadtime_active_o,
  input wire logic osc_halt_o,
  input wire logic ss_discharge_o,
  input wire logic timer_charge_o,
  input wire logic capacitive_mode_o,
  input wire logic overcurrent_latched_o
);
  localparam int CAP_MAX = CMP_TIMEOUT_CYC + 3;
  localparam int REL_MAX = OCP_HOLD_CYC + 6;
  logic [15:0] off_q;
  logic [15:0] dt_q;
  logic [15:0] ss_q;
  logic        seen_q;

  // Gap, dead-time and discharge lengths; they saturate so a long shutdown cannot wrap them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_q  <= 16'h0000;
      dt_q   <= 16'h0000;
      ss_q   <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      off_q  <= (high_side_gate_o || low_side_gate_o) ? 16'h0000 : off_q + {15'h0000, ~&off_q};
      dt_q   <= deadtime_active_o ? dt_q + {15'h0000, ~&dt_q} : 16'h0000;
      ss_q   <= ss_discharge_o ? ss_q + {15'h0000, ~&ss_q} : 16'h0000;
      seen_q <= seen_q || slew_sense_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_no_overlap: assert property (!(high_side_gate_o && low_side_gate_o))
    else $error("both gate commands on");
  a_min_dead: assert property (($rose(high_side_gate_o) || $rose(low_side_gate_o)) |-> off_q >= 16'h003B)
    else $error("gate on before minimum dead time");
  a_fixed_dead: assert property (($rose(high_side_gate_o) || $rose(low_side_gate_o)) && !seen_q
    |-> off_q >= 16'h004B && off_q <= 16'h004E)
    else $error("fixed dead time wrong");
  a_max_dead: assert property (deadtime_active_o && !capacitive_mode_o && !overcurrent_latched_o |-> dt_q <= 16'h00FD)
    else $error("dead time beyond maximum");
  a_cap_timeout: assert property (deadtime_active_o |-> int'(dt_q) <= CAP_MAX)
    else $error("blocked gate not forced on");
  a_cap_halt: assert property (osc_halt_o |-> deadtime_active_o && !high_side_gate_o && !low_side_gate_o)
    else $error("halt without held dead time");
  a_cap_discharge: assert property ($rose(capacitive_mode_o) |-> ss_discharge_o)
    else $error("no discharge on capacitive block");
  a_ss_hold: assert property ($fell(ss_discharge_o) |-> int'(ss_q) >= OCP_HOLD_CYC - 1)
    else $error("discharge released too early");
  a_ocp_entry: assert property ($rose(oc_level1_i) && !ss_discharge_o && !overcurrent_latched_o ##1 oc_level1_i[*3]
    |-> ##[0:2] (ss_discharge_o && timer_charge_o))
    else $error("overcurrent not regulated");
  a_ocp_release: assert property ((timer_charge_o && !oc_level1_i && !timer_first_i && !oc_level2_i)[*3]
    |-> ##[0:REL_MAX] (!timer_charge_o && !ss_discharge_o))
    else $error("overcurrent regulation not released");
  a_hiccup_off: assert property ($rose(timer_shutdown_i) && timer_charge_o
    |-> ##[3:5] (!high_side_gate_o && !low_side_gate_o && !timer_charge_o && ss_discharge_o))
    else $error("no shutdown at timer limit");
  a_latch_off: assert property ((oc_level2_i && !undervoltage_lockout_i)[*3]
    |-> ##[0:2] (overcurrent_latched_o && !high_side_gate_o && !low_side_gate_o))
    else $error("second level did not latch off");

  c_cap: cover property ($rose(capacitive_mode_o));
  c_hiccup: cover property ($rose(timer_shutdown_i) && timer_charge_o);
  c_latch: cover property ($rose(overcurrent_latched_o));
endmodule

`default_nettype wire

// ==== verification/dcs_bridge_model.sv ====
// Half-bridge switch node model that answers gate turn-offs with slew-sense current.
`timescale 1ns/1ps
`default_nettype none

module dcs_bridge_model (
  input  wire logic        clk_i,
  input  wire logic        high_side_gate_i,
  input  wire logic        low_side_gate_i,
  input  wire logic        slew_en_i,
  input  wire logic [15:0] slew_dly_i,
  input  wire logic [15:0] slew_len_i,
  output logic             slew_sense_o
);
  logic        hg_q = 1'b0;
  logic        lg_q = 1'b0;
  logic [15:0] cnt_q = 16'hFFFF;

  // The node starts to move when a gate falls and stops once either transistor conducts again.
  always_ff @(posedge clk_i) begin
    hg_q <= high_side_gate_i;
    lg_q <= low_side_gate_i;
    if ((hg_q && !high_side_gate_i) || (lg_q && !low_side_gate_i)) begin
      cnt_q <= 16'h0000;
    end else if (high_side_gate_i || low_side_gate_i) begin
      cnt_q <= 16'hFFFF;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // A disconnected sense pin never reports current, so it reads low.
  assign slew_sense_o = slew_en_i && cnt_q >= slew_dly_i && cnt_q < slew_dly_i + slew_len_i;
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the dead-time, capacitive-mode and overcurrent sequencer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_i, rst_i, osc_phase_i, slew_sense_i, positive_polarity_flag_i, negative_polarity_flag_i;
  logic oc_level1_i, oc_level2_i, timer_first_i, timer_shutdown_i, timer_restart_i, undervoltage_lockout_i;
  logic high_side_gate_o, low_side_gate_o, deadtime_active_o, osc_halt_o, ss_discharge_o, timer_charge_o;
  logic capacitive_mode_o, overcurrent_latched_o, slew_en;
  logic [15:0] slew_dly, slew_len;
  int          n_mismatch = 0, total_checks = 0, off_n = 0, last_off = 0;

  // Short timeout and hold keep the run brief; expectations below follow these values.
  dcs_sequencer #(.CMP_TIMEOUT_CYC(400), .OCP_HOLD_CYC(20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .osc_phase_i(osc_phase_i), .slew_sense_i(slew_sense_i),
    .positive_polarity_flag_i(positive_polarity_flag_i), .negative_polarity_flag_i(negative_polarity_flag_i),
    .oc_level1_i(oc_level1_i), .oc_level2_i(oc_level2_i), .timer_first_i(timer_first_i),
    .timer_shutdown_i(timer_shutdown_i), .timer_restart_i(timer_restart_i),
    .undervoltage_lockout_i(undervoltage_lockout_i), .high_side_gate_o(high_side_gate_o),
    .low_side_gate_o(low_side_gate_o), .deadtime_active_o(deadtime_active_o), .osc_halt_o(osc_halt_o),
    .ss_discharge_o(ss_discharge_o), .timer_charge_o(timer_charge_o), .capacitive_mode_o(capacitive_mode_o),
    .overcurrent_latched_o(overcurrent_latched_o));
  dcs_bridge_model u_bridge (.clk_i(clk_i), .high_side_gate_i(high_side_gate_o), .low_side_gate_i(low_side_gate_o),
    .slew_en_i(slew_en), .slew_dly_i(slew_dly), .slew_len_i(slew_len), .slew_sense_o(slew_sense_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Length of the last gap with both gates off, in clock cycles.
  always @(posedge clk_i) begin
    if (rst_i || high_side_gate_o || low_side_gate_o) begin
      if (off_n > 0) last_off = off_n;
      off_n = 0;
    end else off_n++;
  end

  task automatic fail(input string msg);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp) fail(msg);
  endtask
  task automatic check_rng(input int lo, input int hi);
    total_checks++;
    if (last_off < lo || last_off > hi) fail($sformatf("dead time %0d", last_off));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic set_slew(input logic en, input logic [15:0] dly, input logic [15:0] len);
    slew_en = en;
    slew_dly = dly;
    slew_len = len;
  endtask
  // Bounded wait for a gate; one more cycle lets the gap monitor record the dead time.
  task automatic wait_gate(input logic hi);
    int k;
    k = 0;
    while ((hi ? high_side_gate_o : low_side_gate_o) !== 1'b1 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 2000) fail("gate never turned on");
    @(negedge clk_i);
  endtask
  task automatic dt(input logic ph, input int lo, input int hi);
    osc_phase_i = ph;
    wait_gate(ph);
    check_rng(lo, hi);
  endtask

  task automatic t_fixed;
    wait_gate(1'b0);
    check_rng(75, 78);
    dt(1'b1, 75, 78);
    dt(1'b0, 75, 78);
  endtask
  task automatic t_adaptive;
    set_slew(1'b1, 16'h0002, 16'h0003);
    dt(1'b1, 59, 62);
    dt(1'b0, 59, 62);
    set_slew(1'b1, 16'h0064, 16'h000A);
    dt(1'b1, 101, 107);
    set_slew(1'b1, 16'h000A, 16'h0064);
    dt(1'b0, 110, 117);
    set_slew(1'b1, 16'h0000, 16'h03E8);
    dt(1'b1, 59, 62);
    dt(1'b0, 250, 253);
  endtask
  // Wrong polarity at low-side turn-off with no slew at all: held until the timer forces it.
  task automatic t_cap_timeout;
    set_slew(1'b0, 16'h0000, 16'h0000);
    negative_polarity_flag_i = 1'b0;
    cyc(3);
    osc_phase_i = 1'b1;
    cyc(100);
    check_bit(capacitive_mode_o, 1'b1, "capacitive mode");
    check_bit(osc_halt_o & deadtime_active_o, 1'b1, "dead time held");
    check_bit(ss_discharge_o, 1'b1, "discharge on block");
    wait_gate(1'b1);
    check_rng(400, 404);
    negative_polarity_flag_i = 1'b1;
    dt(1'b0, 250, 253);
    check_bit(ss_discharge_o | capacitive_mode_o, 1'b0, "discharge kept");
  endtask
  task automatic t_cap_release;
    set_slew(1'b1, 16'h0096, 16'h000A);
    negative_polarity_flag_i = 1'b0;
    cyc(3);
    osc_phase_i = 1'b1;
    cyc(20);
    negative_polarity_flag_i = 1'b1;
    wait_gate(1'b1);
    check_rng(150, 158);
  endtask
  task automatic t_cap_low;
    set_slew(1'b0, 16'h0000, 16'h0000);
    positive_polarity_flag_i = 1'b0;
    cyc(3);
    osc_phase_i = 1'b0;
    cyc(50);
    check_bit(capacitive_mode_o, 1'b1, "capacitive mode low side");
    positive_polarity_flag_i = 1'b1;
    wait_gate(1'b0);
    check_rng(400, 404);
    dt(1'b1, 250, 253);
  endtask
  task automatic t_ocp_regulate;
    oc_level1_i = 1'b1;
    cyc(5);
    check_bit(ss_discharge_o & timer_charge_o, 1'b1, "regulation entry");
    oc_level1_i = 1'b0;
    cyc(8);
    check_bit(ss_discharge_o, 1'b1, "hold too short");
    cyc(20);
    check_bit(ss_discharge_o | timer_charge_o, 1'b0, "no release");
  endtask
  task automatic t_hiccup;
    oc_level1_i = 1'b1;
    timer_restart_i = 1'b0;
    cyc(5);
    timer_first_i = 1'b1;
    cyc(30);
    check_bit(ss_discharge_o & timer_charge_o, 1'b1, "protect lost");
    timer_shutdown_i = 1'b1;
    cyc(6);
    check_bit(high_side_gate_o | low_side_gate_o | timer_charge_o, 1'b0, "not shut down");
    {oc_level1_i, timer_first_i, timer_shutdown_i, osc_phase_i} = 4'h0;
    cyc(30);
    check_bit(high_side_gate_o | low_side_gate_o, 1'b0, "early restart");
    timer_restart_i = 1'b1;
    wait_gate(1'b0);
    check_bit(ss_discharge_o, 1'b0, "restart discharge");
  endtask
  task automatic t_latch;
    oc_level2_i = 1'b1;
    cyc(5);
    check_bit(overcurrent_latched_o & ~low_side_gate_o, 1'b1, "no latch");
    oc_level2_i = 1'b0;
    cyc(20);
    check_bit(overcurrent_latched_o, 1'b1, "latch lost");
    undervoltage_lockout_i = 1'b1;
    cyc(5);
    check_bit(overcurrent_latched_o, 1'b0, "latch not cleared");
    undervoltage_lockout_i = 1'b0;
    wait_gate(1'b0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence: inputs change only just after falling edges.
  initial begin
    {rst_i, osc_phase_i, positive_polarity_flag_i, negative_polarity_flag_i, oc_level1_i, oc_level2_i} = 6'h2C;
    {timer_first_i, timer_shutdown_i, timer_restart_i, undervoltage_lockout_i} = 4'h2;
    set_slew(1'b0, 16'h0000, 16'h0000);
    cyc(3);
    rst_i = 1'b0;
    t_fixed();
    t_adaptive();
    t_cap_timeout();
    t_cap_release();
    t_cap_low();
    t_ocp_regulate();
    t_hiccup();
    t_latch();
    stop_test();
  end

  // The whole run needs under 10000 cycles; this cuts a hang short.
  initial begin
    #160000;
    fail("watchdog expired");
    stop_test();
  end
endmodule

bind dcs_sequencer dcs_seq_assertions #(.CMP_TIMEOUT_CYC(CMP_TIMEOUT_CYC), .OCP_HOLD_CYC(OCP_HOLD_CYC))
  u_chk (.clk_i(clk_i), .rst_i(rst_i), .slew_sense_i(slew_sense_i), .oc_level1_i(oc_level1_i),
    .oc_level2_i(oc_level2_i), .timer_first_i(timer_first_i), .timer_shutdown_i(timer_shutdown_i),
    .undervoltage_lockout_i(undervoltage_lockout_i), .high_side_gate_o(high_side_gate_o),
    .low_side_gate_o(low_side_gate_o), .deadtime_active_o(deadtime_active_o), .osc_halt_o(osc_halt_o),
    .ss_discharge_o(ss_discharge_o), .timer_charge_o(timer_charge_o), .capacitive_mode_o(capacitive_mode_o),
    .overcurrent_latched_o(overcurrent_latched_o));

`default_nettype wire
